// ==== wws_defs.svh ====
// Timing constants and build options for the windowed watchdog supervisor.
// Assumes a 40 MHz mclk; every count derives from a time and that rate.
//
// What this block does
// - Early strobe edge raises fast fault pulse
// - Missing strobe edge raises slow fault pulse
// - First edge after release skips fast check
// - Fault pulse held low about 1 ms
// - Fault pulses only while reset released
// - Timer cleared on edge and reset release
// - In-window edge keeps fault idle, restarts timing
// - Manual reset low asserts reset, clears fault and timer
// - Reset held 180 ms after manual release
// - Undervoltage asserts reset until timeout elapses
// - Manual reset low 1 us always honoured
// - Strobes ignored during reset or fault pulse
// - Timer cleared on valid edge, output release
`ifndef WWS_DEFS_SVH
`define WWS_DEFS_SVH
`define WWS_CLK_HZ        40000000
`define WWS_TICK_US       100
`define WWS_TICK_CYC      ((`WWS_CLK_HZ / 1000000) * `WWS_TICK_US)
`define WWS_FILT_NS       300
`define WWS_FILT_CYC      ((`WWS_FILT_NS * (`WWS_CLK_HZ / 1000000) + 999) / 1000)
`define WWS_MR_NS         1000
`define WWS_MR_CYC        ((`WWS_MR_NS * (`WWS_CLK_HZ / 1000000)) / 1000 - 8)
`define WWS_PULSE_US      1000
`define WWS_PULSE_TICKS   (`WWS_PULSE_US / `WWS_TICK_US)
`define WWS_PULSE_MIN_US  500
`define WWS_PULSE_MAX_US  3000
`define WWS_RST_US        180000
`define WWS_RST_TICKS     (`WWS_RST_US / `WWS_TICK_US)
`define WWS_FAST_A_US     1500
`define WWS_FAST_B_US     15000
`define WWS_FAST_F_US     23000
`define WWS_FAST_G_US     39000
`define WWS_FAST_H_US     719000
`define WWS_SLOW_A_US     10000
`define WWS_SLOW_B_US     100000
`define WWS_SLOW_C_US     300000
`define WWS_SLOW_D_US     10000000
`define WWS_SLOW_E_US     60000000
`define WWS_SLOW_F_US     47000
`define WWS_SLOW_G_US     82000
`define WWS_SLOW_H_US     1300000
`endif

// ==== wws_host_model.sv ====
// Host model: toggles the watchdog strobe with a set half period.
// Assumes the bench changes run and half_cyc just after a falling edge.
`timescale 1ns/10ps
`default_nettype none
module wws_host_model (
  input  wire logic       mclk,     // Supervisor clock
  input  wire logic       run,      // Toggling on; level held when low
  input  wire logic [7:0] half_cyc, // Cycles per strobe level
  output var  logic       strobe    // Strobe pin drive
);
  int cnt; // Cycles spent in current level
  // Toggle off the sampling edge
  initial begin
    strobe = 1'h1;
    cnt = 0;
    forever begin
      @(negedge mclk);
      if (run) begin
        cnt++;
        if (cnt >= int'(half_cyc)) begin // Level held >= 300 ns spacing set by bench
          strobe = ~strobe;
          cnt = 0;
        end
      end else begin
        cnt = 0;
      end
    end
  end
endmodule : wws_host_model
`default_nettype wire

// ==== wws_pkg.sv ====
// Types shared by the windowed watchdog supervisor.
// Assumes wws_defs.svh supplies the numeric constants.
`default_nettype none
package wws_pkg;
  // Supervisor state, one-hot
  typedef enum logic [2:0] {
    WWS_RESET = 3'h1,  // Reset output asserted
    WWS_WATCH = 3'h2,  // Watching strobe edges
    WWS_FAULT = 3'h4   // Fault pulse active
  } wws_state_e;
  // Conditioned input levels and strobe edge
  typedef struct packed {
    logic strobe;      // Filtered strobe level
    logic mr_n;        // Filtered manual reset level
    logic fall;        // Strobe falling edge pulse
  } wws_in_s;
endpackage : wws_pkg
`default_nettype wire

// ==== wws_supervisor.sv ====
// Windowed watchdog supervisor with manual reset and reset sequencer.
// Assumes asynchronous pins; undervoltage comes from an analog comparator.
`timescale 1ns/10ps
`default_nettype none
`include "wws_defs.svh"
module wws_supervisor #(
  parameter int unsigned FAST_TICKS = `WWS_FAST_B_US / `WWS_TICK_US,
  parameter int unsigned SLOW_TICKS = `WWS_SLOW_B_US / `WWS_TICK_US,
  parameter int unsigned TICK_CYC   = `WWS_TICK_CYC,
  parameter int unsigned RST_TICKS  = `WWS_RST_TICKS
) (
  input  wire logic mclk,               // 40 MHz clock
  input  wire logic rstn,               // Async reset, active low
  input  wire logic watchdog_strobe_in, // Strobe pin from host
  input  wire logic manual_reset_in_n,  // Manual reset pin
  input  wire logic undervoltage_in,    // Supply below undervoltage_threshold
  output logic      reset_out_n,        // Reset output, active low
  output logic      fault_pulse_out_n,  // Fault pulse output level
  output logic      fault_pulse_oe      // High while driving fault pin low
);
  localparam int unsigned FILT_CYC = `WWS_FILT_CYC;
  localparam int unsigned MR_CYC   = `WWS_MR_CYC;
  localparam int unsigned PULSE_T  = `WWS_PULSE_TICKS;
  localparam logic [7:0]  FILT_MAX = 8'(FILT_CYC);
  localparam logic [7:0]  MR_MAX   = 8'(MR_CYC);
  localparam logic [15:0] TICK_MAX = 16'(TICK_CYC - 1);
  localparam logic [23:0] FAST_T   = 24'(FAST_TICKS);
  localparam logic [23:0] SLOW_T   = 24'(SLOW_TICKS);
  localparam logic [23:0] PULSE_TK = 24'(PULSE_T);
  localparam logic [23:0] RST_T    = 24'(RST_TICKS);
  localparam logic [23:0] PW_MIN   = 24'((`WWS_PULSE_MIN_US / `WWS_TICK_US) * TICK_CYC);
  localparam logic [23:0] PW_MAX   = 24'((`WWS_PULSE_MAX_US / `WWS_TICK_US) * TICK_CYC);

  // Two-stage synchronisers
  logic [1:0] s_wd_ff, nxt_s_wd;       // Strobe sync chain
  logic [1:0] s_mr_ff, nxt_s_mr;       // Manual reset sync chain
  logic [1:0] s_uv_ff, nxt_s_uv;       // Undervoltage sync chain
  // Filters
  logic       f_wd_ff, nxt_f_wd;       // Filtered strobe
  logic [7:0] c_wd_ff, nxt_c_wd;       // Strobe stability count
  logic       f_mr_ff, nxt_f_mr;       // Filtered manual reset
  logic [7:0] c_mr_ff, nxt_c_mr;       // Manual reset stability count
  // Time base
  logic [15:0] pre_ff, nxt_pre;        // Prescaler
  logic        tick_ff, nxt_tick;      // One tick pulse
  // Supervisor
  wws_pkg::wws_state_e st_ff, nxt_st;  // Main state
  logic [23:0] tmr_ff, nxt_tmr;        // Tick timer
  logic        first_ff, nxt_first;    // Next edge skips fast check
  logic        rst_n_ff, nxt_rst_n;    // Reset output register
  logic        fp_ff, nxt_fp;          // Fault drive register
  logic        fp_n_ff;                // Fault pin level register
  logic [23:0] pw_ff, nxt_pw;          // Cycles with fault driven
  wws_pkg::wws_in_s in;                // Conditioned inputs

  // Synchroniser and filter next values
  always_comb begin
    nxt_s_wd = {s_wd_ff[0], watchdog_strobe_in};
    nxt_s_mr = {s_mr_ff[0], manual_reset_in_n};
    nxt_s_uv = {s_uv_ff[0], undervoltage_in};
    nxt_f_wd = f_wd_ff;
    nxt_c_wd = 8'h00;
    // Strobe level accepted only after it stays stable
    if (s_wd_ff[1] != f_wd_ff) begin
      nxt_c_wd = c_wd_ff + 8'h01;
      if (c_wd_ff >= FILT_MAX) begin
        nxt_f_wd = s_wd_ff[1];
        nxt_c_wd = 8'h00;
      end
    end
    nxt_f_mr = f_mr_ff;
    nxt_c_mr = 8'h00;
    // Manual reset low accepted within 1 us, glitches rejected
    if (s_mr_ff[1] != f_mr_ff) begin
      nxt_c_mr = c_mr_ff + 8'h01;
      if (c_mr_ff >= MR_MAX) begin
        nxt_f_mr = s_mr_ff[1];
        nxt_c_mr = 8'h00;
      end
    end
  end

  // Synchroniser and filter registers
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s_wd_ff <= 2'h3;
      s_mr_ff <= 2'h3;
      s_uv_ff <= 2'h3;
      f_wd_ff <= 1'h1;
      c_wd_ff <= 8'h00;
      f_mr_ff <= 1'h1;
      c_mr_ff <= 8'h00;
    end else begin
      s_wd_ff <= nxt_s_wd;
      s_mr_ff <= nxt_s_mr;
      s_uv_ff <= nxt_s_uv;
      f_wd_ff <= nxt_f_wd;
      c_wd_ff <= nxt_c_wd;
      f_mr_ff <= nxt_f_mr;
      c_mr_ff <= nxt_c_mr;
    end
  end

  // Conditioned inputs, edge from filtered level only
  always_comb begin
    in.strobe = f_wd_ff;
    in.mr_n   = f_mr_ff;
    in.fall   = f_wd_ff & ~nxt_f_wd;
  end

  // Free-running time base next value
  always_comb begin
    nxt_pre  = (pre_ff == TICK_MAX) ? 16'h0000 : pre_ff + 16'h0001;
    nxt_tick = (pre_ff == TICK_MAX);
  end

  // Time base registers
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pre_ff  <= 16'h0000;
      tick_ff <= 1'h0;
    end else begin
      pre_ff  <= nxt_pre;
      tick_ff <= nxt_tick;
    end
  end

  // Supervisor next state
  always_comb begin
    nxt_st    = st_ff;
    nxt_tmr   = tmr_ff;
    nxt_first = first_ff;
    nxt_rst_n = rst_n_ff;
    nxt_fp    = fp_ff;
    case (st_ff)
      // Reset held; timer counts timeout once causes are gone
      wws_pkg::WWS_RESET: begin
        nxt_rst_n = 1'h0;
        nxt_fp    = 1'h0;
        if (!in.mr_n || s_uv_ff[1]) begin
          nxt_tmr = 24'h000000;
        end else if (tmr_ff >= RST_T) begin
          nxt_st    = wws_pkg::WWS_WATCH;
          nxt_rst_n = 1'h1;
          nxt_tmr   = 24'h000000;
          nxt_first = 1'h1;
        end else if (tick_ff) begin
          nxt_tmr = tmr_ff + 24'h000001;
        end
      end
      // Window watching
      wws_pkg::WWS_WATCH: begin
        if (in.fall) begin
          if (!first_ff && tmr_ff < FAST_T) begin
            nxt_st  = wws_pkg::WWS_FAULT;
            nxt_fp  = 1'h1;
            nxt_tmr = 24'h000000;
          end else begin
            nxt_tmr   = 24'h000000;
            nxt_first = 1'h0;
          end
        end else if (tmr_ff >= SLOW_T) begin
          nxt_st  = wws_pkg::WWS_FAULT;
          nxt_fp  = 1'h1;
          nxt_tmr = 24'h000000;
        end else if (tick_ff) begin
          nxt_tmr = tmr_ff + 24'h000001;
        end
      end
      // Fault pulse; strobe edges ignored here
      wws_pkg::WWS_FAULT: begin
        if (tmr_ff >= PULSE_TK) begin
          nxt_st    = wws_pkg::WWS_WATCH;
          nxt_fp    = 1'h0;
          nxt_tmr   = 24'h000000;
          nxt_first = 1'h1;
        end else if (tick_ff) begin
          nxt_tmr = tmr_ff + 24'h000001;
        end
      end
      default: begin
        nxt_st = wws_pkg::WWS_RESET;
      end
    endcase
    // Manual reset or undervoltage overrides everything
    if (!in.mr_n || s_uv_ff[1]) begin
      nxt_st    = wws_pkg::WWS_RESET;
      nxt_rst_n = 1'h0;
      nxt_fp    = 1'h0;
      nxt_tmr   = 24'h000000;
    end
  end

  // Supervisor registers
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_ff    <= wws_pkg::WWS_RESET;
      tmr_ff   <= 24'h000000;
      first_ff <= 1'h1;
      rst_n_ff <= 1'h0;
      fp_ff    <= 1'h0;
      fp_n_ff  <= 1'h1;
    end else begin
      st_ff    <= nxt_st;
      tmr_ff   <= nxt_tmr;
      first_ff <= nxt_first;
      rst_n_ff <= nxt_rst_n;
      fp_ff    <= nxt_fp;
      fp_n_ff  <= ~nxt_fp;
    end
  end

  // Outputs straight from flip-flops
  assign reset_out_n       = rst_n_ff;
  assign fault_pulse_oe    = fp_ff;
  assign fault_pulse_out_n = fp_n_ff;

  // Pulse width count for the width check, cleared between pulses
  always_comb begin
    nxt_pw = fp_ff ? (pw_ff + 24'h000001) : 24'h000000;
  end

  // Pulse width register
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pw_ff <= 24'h000000;
    end else begin
      pw_ff <= nxt_pw;
    end
  end

  // Fault drive only while reset released
  property p_no_fault_in_reset;
    @(posedge mclk) disable iff (!rstn)
      !rst_n_ff |-> !fp_ff;
  endproperty
  a_no_fault_in_reset: assert property (p_no_fault_in_reset)
    else $error("Fault pulse while reset asserted");

  // Early edge in watch state starts a fault
  property p_fast_fault;
    @(posedge mclk) disable iff (!rstn)
      (st_ff == wws_pkg::WWS_WATCH && in.fall && !first_ff && tmr_ff < FAST_T
       && in.mr_n && !s_uv_ff[1]) |=> fp_ff;
  endproperty
  a_fast_fault: assert property (p_fast_fault)
    else $error("Early edge gave no fault");

  // Late window gives slow fault
  property p_slow_fault;
    @(posedge mclk) disable iff (!rstn)
      (st_ff == wws_pkg::WWS_WATCH && !in.fall && tmr_ff >= SLOW_T
       && in.mr_n && !s_uv_ff[1]) |=> fp_ff;
  endproperty
  a_slow_fault: assert property (p_slow_fault)
    else $error("Slow timeout gave no fault");

  // First edge after release never faults
  property p_first_skip;
    @(posedge mclk) disable iff (!rstn)
      (st_ff == wws_pkg::WWS_WATCH && first_ff && in.fall) |=> !fp_ff;
  endproperty
  a_first_skip: assert property (p_first_skip)
    else $error("First edge raised fast fault");

  // Fault pulse not cut by reset stays within its width limits
  property p_pulse_min;
    @(posedge mclk) disable iff (!rstn)
      ($fell(fp_ff) && rst_n_ff) |-> (pw_ff >= PW_MIN && pw_ff <= PW_MAX);
  endproperty
  a_pulse_min: assert property (p_pulse_min)
    else $error("Fault pulse width out of limits");

  // Manual reset low forces reset and fault release
  property p_mr_reset;
    @(posedge mclk) disable iff (!rstn)
      !in.mr_n |=> (!rst_n_ff && !fp_ff && tmr_ff == 24'h000000);
  endproperty
  a_mr_reset: assert property (p_mr_reset)
    else $error("Manual reset did not assert reset");

  // Reset release only after timeout
  property p_rst_release;
    @(posedge mclk) disable iff (!rstn)
      $rose(rst_n_ff) |-> $past(tmr_ff) >= RST_T;
  endproperty
  a_rst_release: assert property (p_rst_release)
    else $error("Reset released before timeout");

  // Undervoltage holds reset
  property p_uv_reset;
    @(posedge mclk) disable iff (!rstn)
      s_uv_ff[1] |=> !rst_n_ff;
  endproperty
  a_uv_reset: assert property (p_uv_reset)
    else $error("Undervoltage did not assert reset");

  // In-window edge clears timer, no fault
  property p_valid_edge;
    @(posedge mclk) disable iff (!rstn)
      (st_ff == wws_pkg::WWS_WATCH && in.fall && tmr_ff >= FAST_T
       && in.mr_n && !s_uv_ff[1]) |=> (!fp_ff && tmr_ff == 24'h000000);
  endproperty
  a_valid_edge: assert property (p_valid_edge)
    else $error("Valid edge mishandled");

  // Strobe edges during fault keep the pulse
  property p_ignore_fault;
    @(posedge mclk) disable iff (!rstn)
      (st_ff == wws_pkg::WWS_FAULT && tmr_ff < PULSE_TK && in.mr_n
       && !s_uv_ff[1]) |=> fp_ff;
  endproperty
  a_ignore_fault: assert property (p_ignore_fault)
    else $error("Fault pulse cut short");
endmodule : wws_supervisor
`default_nettype wire

// ==== wws_supervisor_bench.sv ====
// Self-checking bench for the watchdog supervisor with shortened counts.
// Assumes wws_host_model drives the strobe; the bench drives the rest.
`timescale 1ns/10ps
`default_nettype none
`include "wws_defs.svh"
module wws_supervisor_bench;
  localparam int TC = 8;                      // Cycles per tick
  localparam int RT = 5;                      // Reset timeout ticks
  localparam int ST = 30;                     // Slow window ticks
  localparam int PW = `WWS_PULSE_TICKS * TC;  // Fault pulse cycles
  logic       mclk;        // Clock
  logic       rstn;        // Reset, active low
  logic       mr_n;        // Manual reset drive
  logic       uv;          // Undervoltage drive
  logic       run;         // Host toggling on
  logic [7:0] half;        // Host half period
  wire logic  strobe;      // Strobe from host
  wire logic  rst_n;       // Reset output
  wire logic  fp_n;        // Fault pin value
  wire logic  fp_oe;       // Fault pin enable
  int         errors;      // Mismatches
  int         checks_done; // Comparisons
  int         oe_hi;       // Cycles with fault driven
  int         n;           // Measured cycles

  // Design with ten-tick fast and thirty-tick slow window
  wws_supervisor #(.FAST_TICKS(10), .SLOW_TICKS(ST), .TICK_CYC(TC), .RST_TICKS(RT)) uut (
    .mclk               (mclk),
    .rstn               (rstn),
    .watchdog_strobe_in (strobe),
    .manual_reset_in_n  (mr_n),
    .undervoltage_in    (uv),
    .reset_out_n        (rst_n),
    .fault_pulse_out_n  (fp_n),
    .fault_pulse_oe     (fp_oe)
  );
  // Host on the strobe pin
  wws_host_model host (
    .mclk     (mclk),
    .run      (run),
    .half_cyc (half),
    .strobe   (strobe)
  );

  // Clock, 25 ns period
  initial begin
    mclk = 1'h0;
    forever #12.5 mclk = ~mclk;
  end

  // Verdict and stop
  task automatic end_of_test;
    if (errors == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test

  // Compare one level
  task automatic check_bit(input string nm, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %b seen %b", nm, exp, got);
    end
  endtask : check_bit

  // Compare a count against bounds
  task automatic check_range(input string nm, input int lo, input int hi, input int got);
    checks_done++;
    if (got < lo || got > hi) begin
      errors++;
      $display("BAD %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask : check_range

  // Let cycles pass, counting fault cycles
  task automatic idle(input int c);
    repeat (c) begin
      @(negedge mclk);
      if (fp_oe === 1'h1) oe_hi++;
    end
  endtask : idle

  // Bounded wait for fault enable (0) or reset output (1) to reach a level
  task automatic wait_for(input int sel, input logic v, input int bound);
    n = 0;
    while (((sel == 0) ? fp_oe : rst_n) !== v) begin
      if (n >= bound) begin
        errors++;
        $display("BAD wait %0d expected %b seen timeout", sel, v);
        end_of_test();
      end
      idle(1);
      n++;
    end
  endtask : wait_for

  // Power-up reset timeout
  task automatic t_por;
    wait_for(1, 1'h1, 300);
    check_range("reset hold", (RT - 1) * TC, 300, n);
  endtask : t_por

  // First edge after release is early but not a fault; then slow faults
  task automatic t_first;
    half = 8'h0F;
    run = 1'h1;
    idle(20);
    run = 1'h0;
    oe_hi = 0;
    idle(150);
    check_range("first edge faults", 0, 0, oe_hi);
    wait_for(0, 1'h1, 300);
    wait_for(0, 1'h0, PW + 20);
    check_range("slow pulse", PW - TC + 2, PW + 1, n);
    wait_for(0, 1'h1, 300);
    check_range("slow gap", ST * TC - TC, ST * TC + TC + 4, n);
    wait_for(0, 1'h0, PW + 20);
  endtask : t_first

  // Edges every 150 cycles stay inside the window
  task automatic t_window;
    half = 8'h4B;
    run = 1'h1;
    oe_hi = 0;
    idle(1000);
    check_range("window faults", 0, 0, oe_hi);
  endtask : t_window

  // Edges every 30 cycles are early
  task automatic t_fast;
    half = 8'h0F;
    wait_for(0, 1'h1, 300);
    check_bit("fault pin low", 1'h0, fp_n);
    wait_for(0, 1'h0, PW + 20);
    check_range("fast pulse", PW - TC + 2, PW + 1, n);
  endtask : t_fast

  // One-microsecond manual reset during a fault pulse
  task automatic t_mr;
    wait_for(0, 1'h1, 300);
    mr_n = 1'h0;
    idle(40);
    mr_n = 1'h1;
    wait_for(1, 1'h0, 20);
    idle(2);
    check_bit("mr fault enable", 1'h0, fp_oe);
    check_bit("mr fault pin", 1'h1, fp_n);
    oe_hi = 0;
    wait_for(1, 1'h1, 300);
    check_range("mr hold", (RT - 1) * TC, 300, n);
    check_range("faults in reset", 0, 0, oe_hi);
    run = 1'h0;
  endtask : t_mr

  // Undervoltage holds reset, then timeout
  task automatic t_uv;
    idle(300);
    uv = 1'h1;
    idle(10);
    check_bit("uv reset", 1'h0, rst_n);
    idle(10);
    uv = 1'h0;
    wait_for(1, 1'h1, 300);
    check_range("uv hold", (RT - 1) * TC, RT * TC + 4, n);
  endtask : t_uv

  // Main sequence
  initial begin
    rstn = 1'h0;
    mr_n = 1'h1;
    uv = 1'h0;
    run = 1'h0;
    half = 8'h0F;
    errors = 0;
    checks_done = 0;
    oe_hi = 0;
    n = 0;
    repeat (12) @(negedge mclk);
    check_bit("reset in reset", 1'h0, rst_n);
    check_bit("fault in reset", 1'h0, fp_oe);
    rstn = 1'h1;
    t_por();
    t_first();
    t_window();
    t_fast();
    t_mr();
    t_uv();
    end_of_test();
  end
endmodule : wws_supervisor_bench
`default_nettype wire
